/* cafl_ctrl.sv */
// Counter array control register with overflow, run and per-module match flags.
`timescale 1ns/1ps

module cafl_ctrl (
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RST_I,
  input  wire logic                    OSC_CLK_I,
  input  wire cafl_pkg::cafl_sfr_req_t SFR_REQ_I,
  input  wire cafl_pkg::cafl_evt_t     EVT_I,
  input  wire logic                    WATCHDOG_EN_I,
  input  wire logic                    OVF_IRQ_EN_I,
  input  wire logic [5:0]              MATCH_IRQ_EN_I,
  output logic [7:0]                   SFR_RDATA_O,
  output logic                         COUNTER_RUN_O,
  output logic                         IRQ_O,
  output logic                         WATCHDOG_RESET_O,
  output logic                         SYSTEM_CLOCK_O
);

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q;
  logic       run_q;
  logic       irq_q;
  logic       wdrst_q;
  logic [6:0] div_q;
  logic       system_clock_q;
  logic [2:0] osc_sync_q;
  logic       osc_lvl_q;

  // One-hot mask for a single-bit write.
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  // Decoded write strobes and per-bit write mask and data.
  wire        sel_w      = SFR_REQ_I.addr == cafl_pkg::CTRL_ADDR;
  wire        wr_w       = sel_w & SFR_REQ_I.wr;
  wire [7:0]  mask_w     = ~SFR_REQ_I.bit_wr ? 8'hFF : bit_mask(SFR_REQ_I.bit_sel);
  wire [7:0]  wval_w     = SFR_REQ_I.bit_wr ? {8{SFR_REQ_I.wdata[0]}} : SFR_REQ_I.wdata;
  wire [7:0]  set_w      = {EVT_I.overflow, 1'b0, EVT_I.match};
  wire [7:0]  rd_w       = {ctrl_d[7], ctrl_d[6], ctrl_d[5:0]};
  wire        run_eff_w  = ctrl_d[cafl_pkg::RUN_BIT] | WATCHDOG_EN_I;
  wire [7:0]  irq_en_w   = {OVF_IRQ_EN_I, 1'b0, MATCH_IRQ_EN_I};
  wire        wd_force_w = WATCHDOG_EN_I & wr_w & mask_w[cafl_pkg::WD_MODULE]
                           & wval_w[cafl_pkg::WD_MODULE];

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_w) begin
      ctrl_d = (ctrl_q & ~mask_w) | (wval_w & mask_w);
    end
    ctrl_d = ctrl_d | set_w;
  end

  // Register state; set beats a simultaneous software clear.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= cafl_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // run gating.
  // Watchdog forces the counter on regardless of the stored run bit.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_eff_w;
    end
  end

  // run reads stored value.
  // Read data shows the software-owned run bit, not the forced one.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= cafl_pkg::CTRL_RESET;
    end else begin
      rdata_q <= rd_w;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ctrl_d & irq_en_w);
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wdrst_q <= 1'b0;
    end else begin
      wdrst_q <= wd_force_w;
    end
  end

  // Oscillator input passes three flops; a level counts once stages two and three agree.
  // Each oscillator phase must last two reference cycles, or that edge is lost.
  wire osc_agree_w = osc_sync_q[1] ~^ osc_sync_q[2];
  wire osc_rise_w  = osc_agree_w & osc_sync_q[2] & ~osc_lvl_q;
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_sync_q <= 3'h0;
      osc_lvl_q  <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], OSC_CLK_I};
      if (osc_agree_w) begin
        osc_lvl_q <= osc_sync_q[2];
      end
    end
  end

  // divide by 128.
  // Divider advances on each rising oscillator edge; output toggles every 64 edges.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_q    <= 7'h00;
      system_clock_q <= 1'b0;
    end else if (osc_rise_w) begin
      div_q    <= div_q + 7'h01;
      system_clock_q <= (div_q == (cafl_pkg::SYSTEM_CLOCK_DIV_MAX >> 1)) | (div_q == cafl_pkg::SYSTEM_CLOCK_DIV_MAX)
                  ? ~system_clock_q : system_clock_q;
    end
  end

  assign SFR_RDATA_O      = rdata_q;
  assign COUNTER_RUN_O    = run_q;
  assign IRQ_O            = irq_q;
  assign WATCHDOG_RESET_O = wdrst_q;
  assign SYSTEM_CLOCK_O         = system_clock_q;

  property p_flag_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (ctrl_q[0] && !wr_w) |=> ctrl_q[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared without write.");

  // module flags fall only under a clearing write.
  for (genvar g = 0; g < cafl_pkg::NUM_MODULES; g++) begin : g_clear_only
    property p_clear_only;
      @(posedge REF_CLK_I) disable iff (RST_I)
        (ctrl_q[g] && !ctrl_d[g]) |-> (wr_w && mask_w[g] && !wval_w[g]);
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("Flag fell without clear.");
  end

  property p_match_set;
    @(posedge REF_CLK_I) disable iff (RST_I)
      EVT_I.match[3] |=> ctrl_q[3];
  endproperty
  a_match_set: assert property (p_match_set) else $error("Match did not set flag.");

  property p_ovf_set;
    @(posedge REF_CLK_I) disable iff (RST_I)
      EVT_I.overflow |=> ctrl_q[cafl_pkg::OVF_BIT];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow did not set flag.");

  property p_irq;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (MATCH_IRQ_EN_I[1] && $rose(ctrl_q[1])) |-> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing for set flag.");

  // forcing write and the pulse it raises.
  sequence s_wd_force_wr;
    wd_force_w;
  endsequence

  sequence s_wd_pulse;
    WATCHDOG_RESET_O;
  endsequence

  // forced reset one cycle after write.
  property p_wd_force;
    @(posedge REF_CLK_I) disable iff (RST_I)
      s_wd_force_wr |=> s_wd_pulse;
  endproperty
  a_wd_force: assert property (p_wd_force) else $error("Watchdog reset not forced.");

  // no reset pulse without a forcing write.
  property p_wd_quiet;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !wd_force_w |=> !WATCHDOG_RESET_O;
  endproperty
  a_wd_quiet: assert property (p_wd_quiet) else $error("Spurious watchdog reset.");

  property p_wd_run;
    @(posedge REF_CLK_I) disable iff (RST_I)
      WATCHDOG_EN_I |=> COUNTER_RUN_O;
  endproperty
  a_wd_run: assert property (p_wd_run) else $error("Counter stopped under watchdog.");

  property p_run_read;
    @(posedge REF_CLK_I) disable iff (RST_I)
      !ctrl_q[cafl_pkg::RUN_BIT] && !wr_w |=> !SFR_RDATA_O[cafl_pkg::RUN_BIT];
  endproperty
  a_run_read: assert property (p_run_read) else $error("Run bit read as one.");

  property p_run_read_wd;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (WATCHDOG_EN_I && !ctrl_q[cafl_pkg::RUN_BIT] && !wr_w)
        |=> (COUNTER_RUN_O && !SFR_RDATA_O[cafl_pkg::RUN_BIT]);
  endproperty
  a_run_read_wd: assert property (p_run_read_wd) else $error("Forced run bit read as one.");

  property p_run_off;
    @(posedge REF_CLK_I) disable iff (RST_I)
      (!ctrl_d[cafl_pkg::RUN_BIT] && !WATCHDOG_EN_I) |=> !COUNTER_RUN_O;
  endproperty
  a_run_off: assert property (p_run_off) else $error("Counter ran while disabled.");

endmodule

/* cafl_pkg.sv */
// Package with constants and carrier types for the counter array control flags block.
package cafl_pkg;

  // Register location and layout.
  localparam logic [7:0] CTRL_ADDR      = 8'hD8;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam int         OVF_BIT        = 7;
  localparam int         RUN_BIT        = 6;
  localparam int         NUM_MODULES    = 6;
  localparam int         WD_MODULE      = 5;

  // System clock divider after reset and its counter width.
  localparam int         SYSTEM_CLOCK_DIV     = 128;
  localparam logic [6:0] SYSTEM_CLOCK_DIV_MAX = 7'h7F;

  // Special function register access carried as one bundle.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } cafl_sfr_req_t;

  // Events from the counter and the six modules.
  typedef struct packed {
    logic       overflow;
    logic [5:0] match;
  } cafl_evt_t;

endpackage

/* test_counter_array_control_flags.sv */
// Self-checking testbench for the counter array control flags block.
`timescale 1ns/1ps
module test_counter_array_control_flags;
  logic                    clk, rst, osc, wd_en, ovf_en, run, irq, wd_rst, sclk;
  logic [5:0]              m_en;
  logic [7:0]              rdata;
  cafl_pkg::cafl_sfr_req_t req;
  cafl_pkg::cafl_evt_t     evt;
  int                      n_errors, compares, cyc;
  time                     t0;

  cafl_ctrl i_dut (.REF_CLK_I(clk), .RST_I(rst), .OSC_CLK_I(osc), .SFR_REQ_I(req),
    .EVT_I(evt), .WATCHDOG_EN_I(wd_en), .OVF_IRQ_EN_I(ovf_en), .MATCH_IRQ_EN_I(m_en),
    .SFR_RDATA_O(rdata), .COUNTER_RUN_O(run), .IRQ_O(irq), .WATCHDOG_RESET_O(wd_rst),
    .SYSTEM_CLOCK_O(sclk));

  // Reference clock and a slower oscillator of unrelated phase.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #3;
    forever #40 osc = ~osc;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Compares %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One-cycle register write on falling edges; the leading edge keeps writes apart.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b,
                    input logic [2:0] s);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, bit_wr: b, addr: a, bit_sel: s, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic pulse(input cafl_pkg::cafl_evt_t e);
    evt = e;
    @(negedge clk);
    evt = '0;
  endtask

  task automatic t_run;
    check(rdata, 8'h00);
    wr(8'hD8, 8'h40, 1'b0, 3'h0);
    check({7'h00, run}, 8'h01);
    // A write to a neighbouring address must leave the register alone.
    wr(8'hD9, 8'hFF, 1'b0, 3'h0);
    check(rdata, 8'h40);
    wr(8'hD8, 8'h00, 1'b0, 3'h0);
    check({7'h00, run}, 8'h00);
  endtask

  task automatic t_flags;
    m_en = 6'h3F;
    for (int i = 0; i < 6; i++) begin
      pulse('{overflow: 1'b0, match: 6'h01 << i});
      check(rdata, 8'h01 << i);
      check({7'h00, irq}, 8'h01);
      repeat (5) @(negedge clk);
      check(rdata, 8'h01 << i);
      wr(8'hD8, 8'h00, 1'b1, 3'(i));
      check({7'h00, irq}, 8'h00);
      check(rdata, 8'h00);
    end
    m_en = 6'h00;
    pulse('{overflow: 1'b0, match: 6'h08});
    check({7'h00, irq}, 8'h00);
    check(rdata, 8'h08);
    wr(8'hD8, 8'h00, 1'b0, 3'h0);
  endtask

  task automatic t_ovf;
    ovf_en = 1'b1;
    pulse('{overflow: 1'b1, match: 6'h00});
    check(rdata, 8'h80);
    check({7'h00, irq}, 8'h01);
    wr(8'hD8, 8'h00, 1'b1, 3'h7);
    check({7'h00, irq}, 8'h00);
    check(rdata, 8'h00);
    ovf_en = 1'b0;
  endtask

  task automatic t_wd;
    wd_en = 1'b1;
    wr(8'hD8, 8'h00, 1'b0, 3'h0);
    check({run, rdata[6]}, 8'h02);
    check({7'h00, run}, 8'h01);
    wr(8'hD8, 8'h01, 1'b1, 3'h5);
    check({7'h00, wd_rst}, 8'h01);
    @(negedge clk);
    check({7'h00, wd_rst}, 8'h00);
    // the reset here is forced by software, so timeout conditions never apply.
    wd_en = 1'b0;
    wr(8'hD8, 8'h00, 1'b0, 3'h0);
    check({7'h00, run}, 8'h00);
  endtask

  // The divided clock period is 128 oscillator periods of 80 ns each.
  task automatic t_system_clock;
    @(posedge sclk);
    t0 = $time;
    @(posedge sclk);
    check({7'h00, ($time - t0 > 10220) && ($time - t0 < 10260)}, 8'h01);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    evt = '0;
    wd_en = 1'b0;
    ovf_en = 1'b0;
    m_en = 6'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_run();
    t_flags();
    t_ovf();
    t_wd();
    t_system_clock();
    final_report();
  end
endmodule
